// ### rtl/lpap_pkg.sv
package lpap_pkg;
    // Bank count and counter width
    localparam int unsigned LPAP_NBANK = 8;
    localparam int unsigned LPAP_CW = 10;
    typedef logic [LPAP_CW-1:0] lpap_cnt_t;

    // Command codes on the command pins
    typedef enum logic [2:0]
    {
        LPAP_NOP = 3'h0,
        LPAP_ACT = 3'h1,
        LPAP_RD = 3'h2,
        LPAP_WR = 3'h3,
        LPAP_MWR = 3'h4,
        LPAP_PRE = 3'h5
    } lpap_cmd_t;

    // Register byte offsets
    localparam logic [7:0] LPAP_CTRL_OFF = 8'h00;
    localparam logic [7:0] LPAP_MR1_OFF = 8'h04;
    localparam logic [7:0] LPAP_MR2_OFF = 8'h08;
    localparam logic [7:0] LPAP_LAT_OFF = 8'h0C;
    localparam logic [7:0] LPAP_TIM_OFF = 8'h10;
    localparam logic [7:0] LPAP_STAT_OFF = 8'h14;
    localparam logic [7:0] LPAP_VIOL_OFF = 8'h18;

    // Field positions
    localparam int unsigned LPAP_CTRL_BL32 = 0;
    localparam int unsigned LPAP_CTRL_ODT = 1;
    localparam int unsigned LPAP_MR1_WPRE = 2;
    localparam int unsigned LPAP_MR1_RPST = 7;
    localparam int unsigned LPAP_MR1_NWR_LSB = 8;
    localparam int unsigned LPAP_MR2_NRTP_LSB = 0;

    // Violation flag positions
    localparam int unsigned LPAP_V_BANK = 0;
    localparam int unsigned LPAP_V_PRE = 1;
    localparam int unsigned LPAP_V_CCD = 2;
    localparam int unsigned LPAP_V_WR2RD = 3;
    localparam int unsigned LPAP_V_RD2WR = 4;
    localparam int unsigned LPAP_NVIOL = 5;

    // Reset values
    localparam logic [31:0] LPAP_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] LPAP_MR1_RST = 32'h0000_0A00;
    localparam logic [31:0] LPAP_MR2_RST = 32'h0000_0008;
    localparam logic [31:0] LPAP_LAT_RST = 32'h0600_0814;
    localparam logic [31:0] LPAP_TIM_RST = 32'h0208_100E;

    // Timing counts in link clocks
    localparam lpap_cnt_t LPAP_PRE_GAP = 10'h004;
    localparam lpap_cnt_t LPAP_BL32_EXTRA = 10'h008;
    localparam lpap_cnt_t LPAP_HALF16 = 10'h008;
    localparam lpap_cnt_t LPAP_HALF32 = 10'h010;
    localparam lpap_cnt_t LPAP_ONE = 10'h001;
endpackage : lpap_pkg

// ### rtl/lpap_bank_if.sv
`timescale 1ns/1ns
`default_nettype none
interface lpap_bank_if;
    import lpap_pkg::*;
    logic tick;
    logic hit;
    lpap_cmd_t cmd;
    logic ap;
    logic all;
    lpap_cnt_t rd_ap_dly;
    lpap_cnt_t wr_ap_dly;
    lpap_cnt_t trp_pb;
    lpap_cnt_t trp_ab;
    logic is_open;
    logic prech;
    logic ap_busy;
    logic ap_fire;
    logic bad;
    modport ctl (output tick, hit, cmd, ap, all, rd_ap_dly, wr_ap_dly, trp_pb, trp_ab,
        input is_open, prech, ap_busy, ap_fire, bad);
    modport bank (input tick, hit, cmd, ap, all, rd_ap_dly, wr_ap_dly, trp_pb, trp_ab,
        output is_open, prech, ap_busy, ap_fire, bad);
endinterface : lpap_bank_if
`default_nettype wire

// ### rtl/lpap_bank.sv
`timescale 1ns/1ns
`default_nettype none
module lpap_bank
    import lpap_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Controller side
    lpap_bank_if.bank bi
);
    lpap_cnt_t ap_cnt_ff;
    lpap_cnt_t rp_cnt_ff;
    logic open_ff;
    logic bad_ff;
    logic access;
    logic fire;

    assign access = bi.hit && (bi.cmd == LPAP_RD || bi.cmd == LPAP_WR || bi.cmd == LPAP_MWR);
    assign fire = bi.tick && ap_cnt_ff == LPAP_ONE;

    // Auto-precharge countdown, never cut by later commands
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ap_cnt_ff <= '0;
        else if (bi.tick)
        begin
            if (access && bi.ap && ap_cnt_ff == '0)
                ap_cnt_ff <= (bi.cmd == LPAP_RD) ? bi.rd_ap_dly : bi.wr_ap_dly;
            else if (ap_cnt_ff != '0)
                ap_cnt_ff <= ap_cnt_ff - LPAP_ONE;
        end
    end

    // Precharge period from the latest precharge reaching this bank
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            rp_cnt_ff <= '0;
        else if (bi.tick)
        begin
            if (bi.hit && bi.cmd == LPAP_PRE)
                rp_cnt_ff <= bi.all ? bi.trp_ab : bi.trp_pb;
            else if (fire)
                rp_cnt_ff <= bi.trp_pb;
            else if (rp_cnt_ff != '0)
                rp_cnt_ff <= rp_cnt_ff - LPAP_ONE;
        end
    end

    // Row state and misuse flag
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            open_ff <= 1'b0;
            bad_ff <= 1'b0;
        end
        else
        begin
            if (bi.tick && bi.hit && bi.cmd == LPAP_ACT)
                open_ff <= 1'b1;
            else if (fire || (bi.tick && bi.hit && bi.cmd == LPAP_PRE))
                open_ff <= 1'b0;
            bad_ff <= bi.tick && ((access && ap_cnt_ff != '0)
                || (bi.hit && bi.cmd == LPAP_ACT && (rp_cnt_ff > LPAP_ONE || ap_cnt_ff != '0)));
        end
    end

    assign bi.is_open = open_ff;
    assign bi.prech = rp_cnt_ff != '0;
    assign bi.ap_busy = ap_cnt_ff != '0;
    assign bi.ap_fire = fire;
    assign bi.bad = bad_ff;

    sequence s_ap_cmd;
        bi.tick && access && bi.ap && ap_cnt_ff == '0;
    endsequence

    ap_read_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s_ap_cmd and bi.cmd == LPAP_RD |=> ap_cnt_ff == $past(bi.rd_ap_dly))
        else $error("read auto-precharge delay not loaded");
    ap_write_load_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s_ap_cmd and bi.cmd != LPAP_RD |=> ap_cnt_ff == $past(bi.wr_ap_dly))
        else $error("write auto-precharge delay not loaded");
    ap_fire_rp_a: assert property (@(posedge hclk) disable iff (!hresetn)
        fire && !(bi.hit && bi.cmd == LPAP_PRE) |=> rp_cnt_ff == $past(bi.trp_pb) && !open_ff)
        else $error("internal precharge did not start");
    pre_reload_a: assert property (@(posedge hclk) disable iff (!hresetn)
        bi.tick && bi.hit && bi.cmd == LPAP_PRE |=> rp_cnt_ff == $past(bi.all ? bi.trp_ab : bi.trp_pb))
        else $error("precharge period not restarted");
    no_ap_open_a: assert property (@(posedge hclk) disable iff (!hresetn)
        bi.tick && access && !bi.ap && ap_cnt_ff == '0 |=> ap_cnt_ff == '0)
        else $error("bank scheduled precharge without flag");
    ap_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !bi.tick && ap_cnt_ff != '0 |=> $stable(ap_cnt_ff))
        else $error("auto-precharge count moved without link edge");
endmodule : lpap_bank
`default_nettype wire

// ### rtl/lpap_timing.sv
// Local design decisions: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - write-AP precharge starts tWR after burst
// - nRTP from MR2, nWR from MR1
// - different-bank same-kind bursts every BL/2
// - MR1 bit7 postamble, bit2 preamble
// - precharge period from latest precharge
// - bursts are never truncated or interrupted
// - read-AP precharge after nRTP, +8 BL32
// - CA5 flag selects auto-precharge
module lpap_timing
    import lpap_pkg::*;
#(
    parameter int unsigned NBANK = LPAP_NBANK
)
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Command link pins
    input wire logic lk_ck,
    input wire logic [2:0] lk_cmd,
    input wire logic [2:0] lk_ba,
    input wire logic lk_ap,
    input wire logic lk_all,
    // Bank state
    output logic [NBANK-1:0] bank_open,
    output logic [NBANK-1:0] bank_prech_start
);
    localparam int unsigned PW = 9;

    // Saturating subtraction of counts
    function automatic lpap_cnt_t sat_sub(input lpap_cnt_t a, input lpap_cnt_t b);
        sat_sub = (a > b) ? a - b : '0;
    endfunction : sat_sub

    // Register byte lane merge
    function automatic logic [7:0] reg_off(input logic [31:0] a);
        reg_off = {a[7:2], 2'b00};
    endfunction : reg_off

    logic [31:0] ctrl_ff;
    logic [31:0] mr1_ff;
    logic [31:0] mr2_ff;
    logic [31:0] lat_ff;
    logic [31:0] tim_ff;
    logic [LPAP_NVIOL-1:0] viol_ff;
    logic [LPAP_NVIOL-1:0] nxt_viol;
    logic [31:0] hrdata_ff;
    logic hreadyout_ff;
    logic hresp_ff;
    logic wr_pend_ff;
    logic [7:0] wr_off_ff;
    logic [PW-1:0] pin_s1_ff;
    logic [PW-1:0] pin_s2_ff;
    logic [PW-1:0] pin_s3_ff;
    logic ck_lvl_ff;
    logic tick_ff;
    lpap_cmd_t cmd_ff;
    logic [2:0] ba_ff;
    logic ap_ff;
    logic all_ff;
    lpap_cnt_t pre_gap_ff;
    lpap_cnt_t rd_gap_ff;
    lpap_cnt_t wr_gap_ff;
    lpap_cnt_t rd2wr_ff;
    lpap_cnt_t wr2rd_ff;
    logic [NBANK-1:0] bank_open_ff;
    logic [NBANK-1:0] prech_ff;
    logic [NBANK-1:0] b_open;
    logic [NBANK-1:0] b_prech;
    logic [NBANK-1:0] b_busy;
    logic [NBANK-1:0] b_fire;
    logic [NBANK-1:0] b_bad;
    logic addr_ok;
    logic [7:0] addr_off;
    lpap_cnt_t half;
    lpap_cnt_t rl;
    lpap_cnt_t wl;
    lpap_cnt_t dqsck;
    lpap_cnt_t odtlon;
    lpap_cnt_t todton;
    lpap_cnt_t twtr;
    lpap_cnt_t rpst;
    lpap_cnt_t wpre;
    lpap_cnt_t nwr;
    lpap_cnt_t nrtp;
    lpap_cnt_t rd2wr_val;
    logic is_rd;
    logic is_wr;
    logic is_pre;

    // Field decode of configuration
    assign half = ctrl_ff[LPAP_CTRL_BL32] ? LPAP_HALF32 : LPAP_HALF16;
    assign rl = {2'b00, lat_ff[7:0]};
    assign wl = {2'b00, lat_ff[15:8]};
    assign dqsck = {2'b00, lat_ff[23:16]};
    assign odtlon = {2'b00, lat_ff[31:24]};
    assign twtr = {2'b00, tim_ff[23:16]};
    assign todton = {2'b00, tim_ff[31:24]};
    assign rpst = mr1_ff[LPAP_MR1_RPST] ? LPAP_ONE : '0;
    assign wpre = mr1_ff[LPAP_MR1_WPRE] ? LPAP_ONE + LPAP_ONE : LPAP_ONE;
    assign nwr = {2'b00, mr1_ff[LPAP_MR1_NWR_LSB +: 8]};
    assign nrtp = {2'b00, mr2_ff[LPAP_MR2_NRTP_LSB +: 8]};

    // Read to write turnaround, termination off or on
    assign rd2wr_val = ctrl_ff[LPAP_CTRL_ODT]
        ? sat_sub(rl + dqsck + half + rpst + LPAP_ONE, odtlon + todton)
        : sat_sub(rl + dqsck + half + rpst + wpre, wl);

    // Three-stage pin synchroniser
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
            pin_s3_ff <= '0;
        end
        else
        begin
            pin_s1_ff <= {lk_ck, lk_cmd, lk_ba, lk_ap, lk_all};
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
        end
    end

    // Link edge detect and command capture
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ck_lvl_ff <= 1'b0;
            tick_ff <= 1'b0;
            cmd_ff <= LPAP_NOP;
            ba_ff <= '0;
            ap_ff <= 1'b0;
            all_ff <= 1'b0;
        end
        else
        begin
            if (pin_s2_ff[8] == pin_s3_ff[8])
                ck_lvl_ff <= pin_s3_ff[8];
            tick_ff <= pin_s2_ff[8] && pin_s3_ff[8] && !ck_lvl_ff;
            if (pin_s2_ff[8] && pin_s3_ff[8] && !ck_lvl_ff)
            begin
                cmd_ff <= lpap_cmd_t'(pin_s3_ff[7:5]);
                ba_ff <= pin_s3_ff[4:2];
                ap_ff <= pin_s3_ff[1];
                all_ff <= pin_s3_ff[0];
            end
        end
    end

    assign is_rd = tick_ff && cmd_ff == LPAP_RD;
    assign is_wr = tick_ff && (cmd_ff == LPAP_WR || cmd_ff == LPAP_MWR);
    assign is_pre = tick_ff && cmd_ff == LPAP_PRE;

    // Per-bank auto-precharge trackers
    genvar gi;
    generate
        for (gi = 0; gi < NBANK; gi++)
        begin : g_bank
            lpap_bank_if bif ();
            assign bif.tick = tick_ff;
            assign bif.hit = (ba_ff == 3'(gi)) || (cmd_ff == LPAP_PRE && all_ff);
            assign bif.cmd = cmd_ff;
            assign bif.ap = ap_ff;
            assign bif.all = all_ff;
            assign bif.rd_ap_dly = ctrl_ff[LPAP_CTRL_BL32] ? nrtp + LPAP_BL32_EXTRA : nrtp;
            assign bif.wr_ap_dly = wl + half + nwr + LPAP_ONE;
            assign bif.trp_pb = {2'b00, tim_ff[7:0]};
            assign bif.trp_ab = {2'b00, tim_ff[15:8]};
            assign b_open[gi] = bif.is_open;
            assign b_prech[gi] = bif.prech;
            assign b_busy[gi] = bif.ap_busy;
            assign b_fire[gi] = bif.ap_fire;
            assign b_bad[gi] = bif.bad;
            lpap_bank u_bank (
                .hclk(hclk),
                .hresetn(hresetn),
                .bi(bif.bank)
            );
        end
    endgenerate

    // Command gap counters, all but write-to-read loaded one short so the exact minimum gap is legal
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pre_gap_ff <= '0;
            rd_gap_ff <= '0;
            wr_gap_ff <= '0;
            rd2wr_ff <= '0;
            wr2rd_ff <= '0;
        end
        else if (tick_ff)
        begin
            pre_gap_ff <= is_pre ? LPAP_PRE_GAP - LPAP_ONE : sat_sub(pre_gap_ff, LPAP_ONE);
            rd_gap_ff <= is_rd ? half - LPAP_ONE : sat_sub(rd_gap_ff, LPAP_ONE);
            wr_gap_ff <= is_wr ? half - LPAP_ONE : sat_sub(wr_gap_ff, LPAP_ONE);
            rd2wr_ff <= is_rd ? sat_sub(rd2wr_val, LPAP_ONE) : sat_sub(rd2wr_ff, LPAP_ONE);
            wr2rd_ff <= is_wr ? wl + half + twtr : sat_sub(wr2rd_ff, LPAP_ONE);
        end
    end

    // Illegal command detection, set beats clear
    always_comb
    begin
        nxt_viol = viol_ff;
        if (wr_pend_ff && wr_off_ff == LPAP_VIOL_OFF)
            nxt_viol = viol_ff & ~hwdata[LPAP_NVIOL-1:0];
        if (|b_bad)
            nxt_viol[LPAP_V_BANK] = 1'b1;
        if (is_pre && pre_gap_ff != '0)
            nxt_viol[LPAP_V_PRE] = 1'b1;
        if ((is_rd && rd_gap_ff != '0) || (is_wr && wr_gap_ff != '0))
            nxt_viol[LPAP_V_CCD] = 1'b1;
        if (is_rd && wr2rd_ff != '0)
            nxt_viol[LPAP_V_WR2RD] = 1'b1;
        if (is_wr && rd2wr_ff != '0)
            nxt_viol[LPAP_V_RD2WR] = 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            viol_ff <= '0;
        else
            viol_ff <= nxt_viol;
    end

    // Bank state outputs
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bank_open_ff <= '0;
            prech_ff <= '0;
        end
        else
        begin
            bank_open_ff <= b_open;
            prech_ff <= b_fire;
        end
    end

    assign bank_open = bank_open_ff;
    assign bank_prech_start = prech_ff;

    // AHB-Lite address phase decode
    assign addr_off = reg_off(haddr);
    assign addr_ok = haddr[31:8] == 24'h000000 && addr_off <= LPAP_VIOL_OFF;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_ff <= 1'b0;
            wr_off_ff <= '0;
            hrdata_ff <= '0;
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
        end
        else
        begin
            hreadyout_ff <= 1'b1;
            hresp_ff <= 1'b0;
            wr_pend_ff <= hsel && hready && htrans[1] && hwrite && addr_ok;
            wr_off_ff <= addr_off;
            if (hsel && hready && htrans[1] && !hwrite)
            begin
                unique case (addr_ok ? addr_off : 8'hFF)
                    LPAP_CTRL_OFF: hrdata_ff <= ctrl_ff;
                    LPAP_MR1_OFF: hrdata_ff <= mr1_ff;
                    LPAP_MR2_OFF: hrdata_ff <= mr2_ff;
                    LPAP_LAT_OFF: hrdata_ff <= lat_ff;
                    LPAP_TIM_OFF: hrdata_ff <= tim_ff;
                    LPAP_STAT_OFF: hrdata_ff <= {8'h00, b_busy, b_prech, b_open};
                    LPAP_VIOL_OFF: hrdata_ff <= {{(32-LPAP_NVIOL){1'b0}}, viol_ff};
                    default: hrdata_ff <= 32'h0000_0000;
                endcase
            end
        end
    end

    // AHB-Lite data phase register writes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_ff <= LPAP_CTRL_RST;
            mr1_ff <= LPAP_MR1_RST;
            mr2_ff <= LPAP_MR2_RST;
            lat_ff <= LPAP_LAT_RST;
            tim_ff <= LPAP_TIM_RST;
        end
        else if (wr_pend_ff)
        begin
            if (wr_off_ff == LPAP_CTRL_OFF)
                ctrl_ff <= {30'h0000_0000, hwdata[1:0]};
            if (wr_off_ff == LPAP_MR1_OFF)
                mr1_ff <= {16'h0000, hwdata[15:0]};
            if (wr_off_ff == LPAP_MR2_OFF)
                mr2_ff <= {24'h000000, hwdata[7:0]};
            if (wr_off_ff == LPAP_LAT_OFF)
                lat_ff <= hwdata;
            if (wr_off_ff == LPAP_TIM_OFF)
                tim_ff <= hwdata;
        end
    end

    assign hrdata = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp = hresp_ff;

    sequence s_pre_cmd;
        is_pre;
    endsequence

    ahb_ready_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp)
        else $error("slave stalled or answered error");
    pre_gap_a: assert property (@(posedge hclk) disable iff (!hresetn)
        s_pre_cmd |=> pre_gap_ff == LPAP_PRE_GAP - LPAP_ONE)
        else $error("precharge spacing not armed");
    viol_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
        viol_ff[LPAP_V_PRE] && !(wr_pend_ff && wr_off_ff == LPAP_VIOL_OFF) |=> viol_ff[LPAP_V_PRE])
        else $error("violation flag lost");
    wr2rd_gap_a: assert property (@(posedge hclk) disable iff (!hresetn)
        is_wr |=> wr2rd_ff == $past(wl + half + twtr))
        else $error("write to read gap wrong");
    prech_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(|b_fire) |=> |bank_prech_start)
        else $error("precharge start not reported");
endmodule : lpap_timing
`default_nettype wire

// ### testbench/lpap_ctl_model.sv
`timescale 1ns/1ns
`default_nettype none
module lpap_ctl_model
    import lpap_pkg::*;
(
    // Clock
    input wire logic hclk,
    // Link pins
    output logic lk_ck,
    output logic [2:0] lk_cmd,
    output logic [2:0] lk_ba,
    output logic lk_ap,
    output logic lk_all
);
    int edges = 0;
    // Idle levels at time zero
    initial
    begin
        lk_ck = 1'b0;
        lk_cmd = LPAP_NOP;
        lk_ba = 3'h0;
        lk_ap = 1'b0;
        lk_all = 1'b0;
    end
    // One link period per command, pins held four hclk on each side of the rise
    task automatic issue(input lpap_cmd_t c, input logic [2:0] b, input logic a, input logic al);
        lk_cmd <= c;
        lk_ba <= b;
        lk_ap <= a;
        lk_all <= al;
        repeat (4) @(posedge hclk);
        lk_ck <= 1'b1;
        edges = edges + 1;
        repeat (4) @(posedge hclk);
        lk_ck <= 1'b0;
    endtask : issue
    // Idle edges with don't-care pins toggled, so stale values never look valid
    task automatic idle(input int n);
        repeat (n) issue(LPAP_NOP, ~lk_ba, ~lk_ap, ~lk_all);
    endtask : idle
endmodule : lpap_ctl_model
`default_nettype wire

// ### testbench/lpap_timing_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module lpap_timing_tb_top import lpap_pkg::*;;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, lk_ck, lk_ap, lk_all;
    logic [31:0] haddr, hwdata, hrdata, rd, w;
    logic [1:0] htrans;
    logic [2:0] hsize, lk_cmd, lk_ba;
    logic [7:0] bank_open, bank_prech_start;
    logic [31:0] seed = 32'h00015DA4;
    int n_errors = 0, checks = 0, cyc = 0, e, n, b, nrtp, nwr, wl, g, t;
    int fire_at[8] = '{default: 0};
    int npulse[8] = '{default: 0};
    lpap_cmd_t c;
    logic [7:0] offs[8] = '{LPAP_CTRL_OFF, LPAP_MR1_OFF, LPAP_MR2_OFF, LPAP_LAT_OFF, LPAP_TIM_OFF,
        LPAP_STAT_OFF, LPAP_VIOL_OFF, 8'h1C};
    logic [31:0] rsts[8] = '{LPAP_CTRL_RST, LPAP_MR1_RST, LPAP_MR2_RST, LPAP_LAT_RST, LPAP_TIM_RST,
        32'h0, 32'h0, 32'h0};

    lpap_timing dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .lk_ck(lk_ck), .lk_cmd(lk_cmd), .lk_ba(lk_ba),
        .lk_ap(lk_ap), .lk_all(lk_all), .bank_open(bank_open), .bank_prech_start(bank_prech_start));
    lpap_ctl_model ctl_u (.hclk(hclk), .lk_ck(lk_ck), .lk_cmd(lk_cmd), .lk_ba(lk_ba), .lk_ap(lk_ap),
        .lk_all(lk_all));

    // Clock
    initial
    begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    // Timeout and record of each internal precharge start
    always @(posedge hclk)
    begin
        cyc = cyc + 1;
        if (cyc == 20000)
        begin
            n_errors = n_errors + 1;
            wrap_up();
        end
        for (int i = 0; i < 8; i++)
            if (bank_prech_start[i] === 1'b1)
            begin
                fire_at[i] = ctl_u.edges;
                npulse[i] = npulse[i] + 1;
            end
    end
    // Seeded xorshift source
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    // Compare one result word
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks = checks + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Single AHB-Lite word transfer, waiting on hready in both phases; don't-care fields random
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
        logic [31:0] r;
        r = xs();
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        hwdata <= r;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= r[0];
        haddr <= r;
        htrans <= 2'h0;
        hwrite <= r[1];
        hsize <= r[4:2];
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
        // Read data is registered at the address edge, so a write lands first
        if (wr)
            @(posedge hclk);
    endtask : ahb
    // Verdict
    task automatic wrap_up();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up
    // Main sequence
    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        wl = int'(LPAP_LAT_RST[15:8]);
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        // Reset values and an unmapped word
        for (int i = 0; i < 8; i++)
        begin
            ahb(1'b0, offs[i], 32'h0, rd);
            chk("reset value", rsts[i], rd);
        end
        // Auto-precharge start per command and burst length
        for (int bl = 0; bl < 2; bl++)
        begin
            ahb(1'b1, LPAP_CTRL_OFF, 32'(bl), rd);
            nrtp = 4 + int'(xs() % 8);
            nwr = 4 + int'(xs() % 8);
            ahb(1'b1, LPAP_MR2_OFF, 32'(nrtp), rd);
            w = 32'(nwr << 8) | (xs() & 32'h00000084);
            ahb(1'b1, LPAP_MR1_OFF, w, rd);
            ahb(1'b0, LPAP_MR1_OFF, 32'h0, rd);
            chk("mr1", w, rd);
            for (int k = 0; k < 3; k++)
            begin
                b = bl * 3 + k;
                c = (k == 0) ? LPAP_RD : (k == 1) ? LPAP_WR : LPAP_MWR;
                n = (k == 0) ? nrtp + 8 * bl : wl + (8 << bl) + nwr + 1;
                ctl_u.issue(LPAP_ACT, 3'(b), 1'b0, 1'b0);
                ctl_u.issue(c, 3'(b), 1'b1, 1'b0);
                e = ctl_u.edges;
                ctl_u.idle(1);
                chk("open before", 32'h1, {31'h0, bank_open[b]});
                ctl_u.idle(n + 1);
                chk("start edge", 32'(e + n), 32'(fire_at[b]));
                chk("pulse count", 32'h1, 32'(npulse[b]));
                chk("open after", 32'h0, {31'h0, bank_open[b]});
            end
        end
        // Write without the flag keeps the row open
        ctl_u.issue(LPAP_ACT, 3'h6, 1'b0, 1'b0);
        ctl_u.issue(LPAP_WR, 3'h6, 1'b0, 1'b0);
        ctl_u.idle(40);
        chk("no start", 32'h0, 32'(npulse[6]));
        chk("still open", 32'h1, {31'h0, bank_open[6]});
        // Precharge spacing of four edges is legal, three is not
        ahb(1'b1, LPAP_VIOL_OFF, 32'h0000001F, rd);
        ctl_u.issue(LPAP_PRE, 3'h6, 1'b0, 1'b0);
        ctl_u.idle(3);
        ctl_u.issue(LPAP_PRE, 3'h0, 1'b0, 1'b1);
        ctl_u.idle(2);
        ahb(1'b0, LPAP_VIOL_OFF, 32'h0, rd);
        chk("viol legal", 32'h0, rd);
        ctl_u.issue(LPAP_PRE, 3'h2, 1'b0, 1'b0);
        ctl_u.idle(2);
        ahb(1'b0, LPAP_VIOL_OFF, 32'h0, rd);
        chk("viol spacing", 32'h2, rd);
        ahb(1'b1, LPAP_VIOL_OFF, 32'h2, rd);
        ahb(1'b0, LPAP_VIOL_OFF, 32'h0, rd);
        chk("viol clear", 32'h0, rd);
        // Same-bank write while auto-precharge pends, at exactly half a burst
        ctl_u.idle(20);
        ctl_u.issue(LPAP_ACT, 3'h7, 1'b0, 1'b0);
        ctl_u.issue(LPAP_WR, 3'h7, 1'b1, 1'b0);
        ctl_u.idle(15);
        ctl_u.issue(LPAP_WR, 3'h7, 1'b0, 1'b0);
        ctl_u.idle(2);
        ahb(1'b0, LPAP_VIOL_OFF, 32'h0, rd);
        chk("viol bank", 32'h1, rd);
        // Second reset in mid-run restores defaults
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, LPAP_VIOL_OFF, 32'h0, rd);
        chk("viol after reset", 32'h0, rd);
        // Write-to-read, read-to-write, precharge-to-activate and precharge spacing gaps at their exact minimum with default settings are legal
        n = int'(LPAP_MR1_RST[15:8]);
        t = n + int'(LPAP_TIM_RST[7:0]) - int'(LPAP_TIM_RST[23:16]);
        g = int'(LPAP_LAT_RST[7:0]) + int'(LPAP_LAT_RST[23:16]) + 8 + int'(LPAP_MR1_RST[7]);
        ctl_u.issue(LPAP_ACT, 3'h3, 1'b0, 1'b0);
        ctl_u.issue(LPAP_ACT, 3'h4, 1'b0, 1'b0);
        ctl_u.issue(LPAP_ACT, 3'h5, 1'b0, 1'b0);
        ctl_u.issue(LPAP_WR, 3'h3, 1'b1, 1'b0);
        ctl_u.idle(wl + 8 + int'(LPAP_TIM_RST[23:16]));
        ctl_u.issue(LPAP_RD, 3'h4, 1'b1, 1'b0);
        ctl_u.idle(t - 1);
        ctl_u.issue(LPAP_ACT, 3'h3, 1'b0, 1'b0);
        ctl_u.idle(g - wl + int'(LPAP_MR1_RST[2]) - t);
        ctl_u.issue(LPAP_WR, 3'h5, 1'b0, 1'b0);
        ctl_u.idle(wl + 8 + n);
        ctl_u.issue(LPAP_PRE, 3'h5, 1'b0, 1'b0);
        ctl_u.idle(3);
        ctl_u.issue(LPAP_PRE, 3'h4, 1'b0, 1'b0);
        ctl_u.idle(1);
        ahb(1'b0, LPAP_VIOL_OFF, 32'h0, rd);
        chk("viol minimum gaps", 32'h0, rd);
        // Termination on with the long preamble shortens the read to write gap
        ahb(1'b1, LPAP_CTRL_OFF, 32'h2, rd);
        ahb(1'b1, LPAP_MR1_OFF, LPAP_MR1_RST | 32'h4, rd);
        ctl_u.issue(LPAP_ACT, 3'h6, 1'b0, 1'b0);
        ctl_u.issue(LPAP_ACT, 3'h7, 1'b0, 1'b0);
        ctl_u.issue(LPAP_RD, 3'h6, 1'b1, 1'b0);
        ctl_u.idle(g - int'(LPAP_LAT_RST[31:24]) - int'(LPAP_TIM_RST[31:24]));
        ctl_u.issue(LPAP_WR, 3'h7, 1'b0, 1'b0);
        ctl_u.idle(1);
        ahb(1'b0, LPAP_VIOL_OFF, 32'h0, rd);
        chk("viol termination gap", 32'h0, rd);
        wrap_up();
    end
endmodule : lpap_timing_tb_top
`default_nettype wire
